// >>> common/fcds_defs.vh
`ifndef FCDS_DEFS_VH
`define FCDS_DEFS_VH

// command bytes
`define FCDS_UNLOCK1_DATA 8'hAA
`define FCDS_UNLOCK2_DATA 8'h55
`define FCDS_UNLOCK1_ADDR 12'h555
`define FCDS_UNLOCK2_ADDR 12'hAAA
`define FCDS_CMD_ID 8'h90
`define FCDS_CMD_PROG 8'hA0
`define FCDS_CMD_ERASE 8'h80
`define FCDS_CMD_SECT 8'h30
`define FCDS_CMD_BULK 8'h10
`define FCDS_CMD_SUSP 8'hB0
`define FCDS_CMD_RESUME 8'h30
`define FCDS_CMD_RESET 8'hF0
`define FCDS_CMD_BYPASS 8'h20
`define FCDS_CMD_BYP_EXIT 8'h00

// query answers
`define FCDS_PROT_NO 8'h00
`define FCDS_PROT_YES 8'h01
`define FCDS_QA_ID 2'h1
`define FCDS_QA_PROT 2'h2

// status byte bit positions
`define FCDS_BIT_POLL 7
`define FCDS_BIT_TOGGLE 6
`define FCDS_BIT_FAIL 5
`define FCDS_BIT_WINDOW 3

// times in ns and the clock period
`define FCDS_CLK_NS 8
`define FCDS_APPEND_NS 80000
`define FCDS_ALLPROT_NS 100000
`define FCDS_APPEND_CYC (`FCDS_APPEND_NS / `FCDS_CLK_NS)
`define FCDS_ALLPROT_CYC (`FCDS_ALLPROT_NS / `FCDS_CLK_NS)
`define FCDS_GAP_CYC 1000

`endif

// >>> design/fcds_sync.v
`timescale 1ns/1ps
// three-stage pin synchroniser; change counted when stages two and three agree
module fcds_sync #(
	parameter W = 1
)
(
	// clock and reset
	input wire clk_in,
	input wire sys_rst_in,
	// pin side
	input wire [W-1:0] d_in,
	// clock side
	output reg [W-1:0] q_out
);
	reg [W-1:0] s1_r;
	reg [W-1:0] s2_r;
	reg [W-1:0] s3_r;
	integer i;
	always @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			s1_r <= {W{1'b0}};
			s2_r <= {W{1'b0}};
			s3_r <= {W{1'b0}};
			q_out <= {W{1'b0}};
		end
		else
		begin
			s1_r <= d_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			for (i = 0; i < W; i = i + 1)
				if (s2_r[i] == s3_r[i])
					q_out[i] <= s3_r[i];
		end
	end
endmodule // fcds_sync

// >>> design/fcds_timer.v
`timescale 1ns/1ps
// down counter: load on start_in, done_out pulses on expiry
module fcds_timer #(
	parameter W = 16
)
(
	// clock and reset
	input wire clk_in,
	input wire sys_rst_in,
	// control
	input wire start_in,
	input wire stop_in,
	input wire [W-1:0] load_in,
	// state
	output reg busy_out,
	output reg done_out
);
	reg [W-1:0] cnt_r;
	always @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			cnt_r <= {W{1'b0}};
			busy_out <= 1'b0;
			done_out <= 1'b0;
		end
		else
		begin
			done_out <= 1'b0;
			if (start_in)
			begin
				cnt_r <= load_in;
				busy_out <= 1'b1;
			end
			else if (stop_in)
				busy_out <= 1'b0;
			else if (busy_out)
			begin
				if (cnt_r <= {{(W-1){1'b0}}, 1'b1})
				begin
					busy_out <= 1'b0;
					done_out <= 1'b1;
				end
				cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule // fcds_timer

// >>> design/fcds_top.v
`timescale 1ns/1ps
`include "fcds_defs.vh"
// What this block does
// R1: after id read, protection read or fail, stay out of read until reset command
// R2: protection query at A1:A0=10 answers 00h unprotected, 01h protected
// R3: host must not command an array it is fetching code from
// R4: extra sector confirms accepted only within 80 us of the previous one
// R5: erase suspended still serves reads, programs elsewhere and queries
// R6: suspend accepted only while sector erase runs; the code also accepts it while bulk erase runs
// R7: resume accepted only while erase suspended
// R8: flash writes decode as command bytes; gaps must beat the time-out
// R9: bad byte or excessive gap returns the decoder to read mode; in bypass the code returns it to bypass instead
// R10: commands open with AAh at X555h then 55h at XAAAh, unless bypass
// R11: address bits 15..12 ignored in commands; a sector select must be high
// R12: primary select routes to primary array, secondary to secondary; id primary only
// R13: read mode after reset and reset command; plain reads return contents
// R14: host holds selects low and write strobe high during power-up
// R15: id query is three writes then one read returning the id code
// R16: status byte: poll on 7, toggle on 6, fail on 5, window on 3
// R17: while programming poll bit is inverse of written bit 7
// R18: status valid after fourth program write or sixth erase write
// R19: poll bit reads 0 during erase, stored value after
// R20: program into protected sector is ignored
// R21: all-protected erase: poll 0, toggle about 100 us, then data
// R22: toggle bit inverts on each read while algorithm runs
// R23: fail bit 0 normally, set on failure, cleared by reset command; in bypass the code does not clear it
// R24: window bit 0 after each sector confirm until window expires, then 1
// R25: bypass entered by unlock writes then 20h; only bypass commands valid
// R26: bypass program is A0h then data; 90h then 00h exits to read mode
// R27: decode program, sector and bulk erase, suspend, resume and reset
// R28: command gap time-out is a clock-cycle parameter
module fcds_top #(
	parameter GAP_CYC = `FCDS_GAP_CYC,
	parameter APPEND_CYC = `FCDS_APPEND_CYC,
	parameter ALLPROT_CYC = `FCDS_ALLPROT_CYC,
	parameter [7:0] DEVICE_ID = 8'h5A // arbitrary value
)
(
	// clock and reset
	input wire clk_in,
	input wire sys_rst_in,
	// bus pins
	input wire wr_n_in,
	input wire rd_n_in,
	input wire [15:0] addr_in,
	input wire [7:0] data_in,
	input wire [7:0] primary_sector_selects_in,
	input wire [3:0] secondary_sector_selects_in,
	// algorithm side
	input wire [7:0] mem_data_in,
	input wire sect_prot_in,
	input wire algo_done_in,
	input wire algo_fail_in,
	// read data
	output reg [7:0] rd_data_out,
	// algorithm requests
	output reg prog_start_out,
	output reg erase_start_out,
	output reg erase_bulk_out,
	output reg sect_add_out,
	output reg erase_suspend_out,
	output reg erase_resume_out,
	output reg target_secondary_out,
	output reg [15:0] target_addr_out,
	output reg [7:0] target_data_out,
	output reg busy_out,
	output reg suspended_out,
	output reg read_mode_out
);
	localparam ST_READ = 4'h0;
	localparam ST_U1 = 4'h1;
	localparam ST_U2 = 4'h2;
	localparam ST_PROG = 4'h3;
	localparam ST_E3 = 4'h4;
	localparam ST_E4 = 4'h5;
	localparam ST_E5 = 4'h6;
	localparam ST_QUERY = 4'h7;
	localparam ST_BYP = 4'h8;
	localparam ST_BYP_PROG = 4'h9;
	localparam ST_BYP_EXIT = 4'hA;
	localparam ST_HOLD = 4'hB;
	localparam OP_NONE = 2'h0;
	localparam OP_PROG = 2'h1;
	localparam OP_ERASE = 2'h2;

	// ************************************
	// pin synchronisers and strobe edges
	// ************************************
	wire [37:0] pins_s;
	reg wr_n_d_r;
	reg rd_n_d_r;
	fcds_sync #(.W(38)) u_sync (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.d_in({wr_n_in, rd_n_in, addr_in, primary_sector_selects_in,
			secondary_sector_selects_in, data_in}),
		.q_out(pins_s)
	);
	wire wr_n_s = pins_s[37];
	wire rd_n_s = pins_s[36];
	wire [15:0] addr_s = pins_s[35:20];
	wire prim_sel = |pins_s[19:12];
	wire sec_sel = |pins_s[11:8];
	wire any_sel = prim_sel | sec_sel;
	wire wr_rise = wr_n_s & ~wr_n_d_r;
	wire rd_fall = ~rd_n_s & rd_n_d_r;
	wire cmd_wr = wr_rise & any_sel; // R8 R11
	// data passes the same three stages as the write strobe
	wire [7:0] wd = pins_s[7:0];

	function addr_is;
		input [15:0] a;
		input [11:0] v;
		begin
			addr_is = (a[11:0] == v); // R11
		end
	endfunction

	// ************************************
	// decoder state
	// ************************************
	reg [3:0] st_r;
	reg [3:0] st_nxt;
	reg [1:0] op_r;
	reg suspended_r;
	reg fail_r;
	reg toggle_r;
	reg [1:0] query_r;
	reg [15:0] gap_r;
	reg exp_poll_r;
	reg win_open_r;
	reg byp_r;

	wire win_busy;
	wire win_done;
	wire ap_busy;
	wire ap_done;
	reg win_start;
	reg ap_start;
	fcds_timer #(.W(16)) u_win (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.start_in(win_start),
		.stop_in(1'b0),
		.load_in(APPEND_CYC[15:0]),
		.busy_out(win_busy),
		.done_out(win_done)
	);
	fcds_timer #(.W(16)) u_ap (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.start_in(ap_start),
		.stop_in(1'b0),
		.load_in(ALLPROT_CYC[15:0]),
		.busy_out(ap_busy),
		.done_out(ap_done)
	);

	wire unl1 = (wd == `FCDS_UNLOCK1_DATA) && addr_is(addr_s, `FCDS_UNLOCK1_ADDR); // R10
	wire unl2 = (wd == `FCDS_UNLOCK2_DATA) && addr_is(addr_s, `FCDS_UNLOCK2_ADDR); // R10
	wire at555 = addr_is(addr_s, `FCDS_UNLOCK1_ADDR);
	wire running = (op_r != OP_NONE) && !suspended_r;
	wire gap_out = (gap_r >= GAP_CYC[15:0]); // R28
	wire mid_seq = (st_r != ST_READ) && (st_r != ST_BYP) && (st_r != ST_HOLD)
		&& (st_r != ST_QUERY); // R1

	// next-state decode of command bytes
	always @*
	begin
		st_nxt = st_r;
		if (mid_seq && gap_out)
			st_nxt = byp_r ? ST_BYP : ST_READ; // R9
		else if (cmd_wr)
		begin
			case (st_r)
				ST_READ, ST_HOLD:
				begin
					if (wd == `FCDS_CMD_RESET)
						st_nxt = ST_READ; // R1 R23
					else if (st_r == ST_HOLD)
						st_nxt = ST_HOLD; // R1
					else if (unl1 && (!running || win_open_r))
						st_nxt = ST_U1;
					else
						st_nxt = ST_READ; // R9
				end
				ST_U1: st_nxt = unl2 ? ST_U2 : ST_READ; // R9 R10
				ST_U2:
				begin
					if (!at555)
						st_nxt = ST_READ;
					else if (wd == `FCDS_CMD_ID)
						st_nxt = ST_QUERY; // R15
					else if (wd == `FCDS_CMD_PROG && op_r != OP_PROG)
						st_nxt = ST_PROG;
					else if (wd == `FCDS_CMD_ERASE && op_r == OP_NONE)
						st_nxt = ST_E3;
					else if (wd == `FCDS_CMD_BYPASS && op_r == OP_NONE)
						st_nxt = ST_BYP; // R25
					else
						st_nxt = ST_READ;
				end
				ST_E3: st_nxt = unl1 ? ST_E4 : ST_READ;
				ST_E4: st_nxt = unl2 ? ST_E5 : ST_READ;
				ST_E5: st_nxt = ST_READ;
				ST_PROG: st_nxt = ST_READ;
				ST_QUERY: st_nxt = (wd == `FCDS_CMD_RESET) ? ST_READ : ST_QUERY;
				ST_BYP:
				begin
					if (wd == `FCDS_CMD_PROG)
						st_nxt = ST_BYP_PROG; // R26
					else if (wd == `FCDS_CMD_ID)
						st_nxt = ST_BYP_EXIT; // R26
					else
						st_nxt = ST_BYP; // R25
				end
				ST_BYP_PROG: st_nxt = ST_BYP;
				ST_BYP_EXIT: st_nxt = (wd == `FCDS_CMD_BYP_EXIT) ? ST_READ : ST_BYP;
				default: st_nxt = ST_READ;
			endcase
		end
	end

	// ************************************
	// sequencer registers
	// ************************************
	wire do_prog = cmd_wr && !gap_out && (st_r == ST_PROG || st_r == ST_BYP_PROG); // R18
	wire do_erase = cmd_wr && !gap_out && (st_r == ST_E5); // R18 R27
	wire do_sect = do_erase && (wd == `FCDS_CMD_SECT);
	wire do_bulk = do_erase && (wd == `FCDS_CMD_BULK) && at555;
	wire do_append = cmd_wr && (st_r == ST_READ) && win_open_r && (wd == `FCDS_CMD_SECT)
		&& op_r == OP_ERASE; // R4
	wire do_susp = cmd_wr && (wd == `FCDS_CMD_SUSP) && op_r == OP_ERASE && !suspended_r
		&& !win_open_r && (st_r == ST_READ); // R6
	wire do_resume = cmd_wr && (wd == `FCDS_CMD_RESUME) && suspended_r
		&& (st_r == ST_READ); // R7

	always @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			st_r <= ST_READ; // R13
			op_r <= OP_NONE;
			suspended_r <= 1'b0;
			fail_r <= 1'b0;
			toggle_r <= 1'b0;
			query_r <= 2'h0;
			gap_r <= 16'h0000;
			exp_poll_r <= 1'b0;
			win_open_r <= 1'b0;
			byp_r <= 1'b0;
			wr_n_d_r <= 1'b1;
			rd_n_d_r <= 1'b1;
			prog_start_out <= 1'b0;
			erase_start_out <= 1'b0;
			erase_bulk_out <= 1'b0;
			sect_add_out <= 1'b0;
			erase_suspend_out <= 1'b0;
			erase_resume_out <= 1'b0;
			target_secondary_out <= 1'b0;
			target_addr_out <= 16'h0000;
			target_data_out <= 8'h00;
			busy_out <= 1'b0;
			suspended_out <= 1'b0;
			read_mode_out <= 1'b1;
			rd_data_out <= 8'h00;
			win_start <= 1'b0;
			ap_start <= 1'b0;
		end
		else
		begin
			wr_n_d_r <= wr_n_s;
			rd_n_d_r <= rd_n_s;
			st_r <= st_nxt;
			if (st_nxt == ST_BYP)
				byp_r <= 1'b1;
			else if (st_nxt == ST_READ)
				byp_r <= 1'b0;
			// gap counter restarts on each command byte
			if (cmd_wr || !mid_seq)
				gap_r <= 16'h0000; // R8
			else if (!gap_out)
				gap_r <= gap_r + 16'h0001;
			prog_start_out <= 1'b0;
			erase_start_out <= 1'b0;
			sect_add_out <= 1'b0;
			erase_suspend_out <= 1'b0;
			erase_resume_out <= 1'b0;
			win_start <= 1'b0;
			ap_start <= 1'b0;
			if (cmd_wr && st_r == ST_U2 && st_nxt == ST_QUERY)
				query_r <= 2'h0;
			if (do_prog && !sect_prot_in) // R20
			begin
				op_r <= OP_PROG;
				prog_start_out <= 1'b1;
				target_addr_out <= addr_s;
				target_data_out <= wd;
				target_secondary_out <= sec_sel; // R12
				exp_poll_r <= ~wd[7]; // R17
			end
			else if (do_sect || do_bulk)
			begin
				op_r <= OP_ERASE;
				erase_start_out <= 1'b1;
				erase_bulk_out <= do_bulk;
				target_addr_out <= addr_s;
				target_secondary_out <= sec_sel; // R12
				exp_poll_r <= 1'b0; // R19
				win_open_r <= do_sect;
				win_start <= do_sect; // R24
				if (sect_prot_in || do_bulk)
					ap_start <= sect_prot_in; // R21
			end
			else if (do_append)
			begin
				sect_add_out <= 1'b1; // R4
				target_addr_out <= addr_s;
				win_start <= 1'b1; // R24
			end
			if (win_done)
				win_open_r <= 1'b0; // R24
			if (do_susp)
			begin
				suspended_r <= 1'b1; // R6
				erase_suspend_out <= 1'b1;
			end
			if (do_resume)
			begin
				suspended_r <= 1'b0; // R7
				erase_resume_out <= 1'b1;
			end
			// completion from the algorithm or the all-protected timer
			if ((algo_done_in || ap_done) && running && !ap_start && !prog_start_out
				&& !erase_start_out)
			begin
				op_r <= OP_NONE;
				win_open_r <= 1'b0;
			end
			// failure sets; reset command clears it outside bypass only; set wins
			if (running && algo_fail_in)
			begin
				fail_r <= 1'b1; // R23
				op_r <= OP_NONE;
			end
			else if (cmd_wr && wd == `FCDS_CMD_RESET && !byp_r)
				fail_r <= 1'b0; // R23
			if (fail_r && st_r == ST_READ)
				st_r <= ST_HOLD; // R1
			// read side: query answer, status or contents
			if (rd_fall && any_sel)
			begin
				if (st_r == ST_QUERY && addr_s[1:0] == `FCDS_QA_ID && prim_sel)
					rd_data_out <= DEVICE_ID; // R15 R12
				else if (st_r == ST_QUERY && addr_s[1:0] == `FCDS_QA_PROT)
					rd_data_out <= sect_prot_in ? `FCDS_PROT_YES : `FCDS_PROT_NO; // R2
				else if ((running || fail_r) && !(suspended_r))
				begin
					rd_data_out <= mem_data_in;
					rd_data_out[`FCDS_BIT_POLL] <= exp_poll_r; // R16 R17 R19
					rd_data_out[`FCDS_BIT_TOGGLE] <= toggle_r; // R22
					rd_data_out[`FCDS_BIT_FAIL] <= fail_r; // R23
					rd_data_out[`FCDS_BIT_WINDOW] <= ~win_open_r; // R24
					toggle_r <= ~toggle_r; // R22
				end
				else
					rd_data_out <= mem_data_in; // R5 R13
			end
			busy_out <= running | ap_busy;
			suspended_out <= suspended_r;
			read_mode_out <= (st_r == ST_READ) && !fail_r;
		end
	end
endmodule // fcds_top

// >>> dv/fcds_top_assertions.sv
`timescale 1ns/1ps
// ****
// port checker
// ****
module fcds_top_assertions
(
	// clock and reset
	input wire clk_in,
	input wire sys_rst_in,
	// watched inputs
	input wire rd_n_in,
	input wire sect_prot_in,
	// watched outputs
	input wire [7:0] rd_data_out,
	input wire prog_start_out,
	input wire erase_start_out,
	input wire sect_add_out,
	input wire erase_suspend_out,
	input wire erase_resume_out,
	input wire busy_out,
	input wire suspended_out,
	input wire read_mode_out
);
	reg [3:0] rd_hi_r;
	// cycles since the read strobe was last low, saturating at 15
	always @(posedge clk_in)
	begin
		if (sys_rst_in || !rd_n_in)
			rd_hi_r <= 4'h0;
		else if (rd_hi_r != 4'hF)
			rd_hi_r <= rd_hi_r + 4'h1;
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	AST_RST_READ: assert property ($fell(sys_rst_in) |-> read_mode_out && rd_data_out == 8'h00)
		else $error("not in read mode after reset");
	AST_PROG_BUSY: assert property (prog_start_out |=> busy_out)
		else $error("no busy after program start");
	AST_ERASE_BUSY: assert property (erase_start_out |=> busy_out)
		else $error("no busy after erase start");
	AST_SUSP_RUNNING: assert property (erase_suspend_out |-> !$past(suspended_out) ##1 suspended_out)
		else $error("suspend outside running erase");
	AST_RESUME_SUSP: assert property (erase_resume_out |-> $past(suspended_out) ##1 !suspended_out)
		else $error("resume outside suspend");
	AST_PROT_IGNORED: assert property (prog_start_out |-> !sect_prot_in)
		else $error("program into protected sector");
	AST_ONE_CMD: assert property ($onehot0({prog_start_out, erase_start_out, sect_add_out,
		erase_suspend_out, erase_resume_out}))
		else $error("two commands at once");
	AST_RD_STANDS: assert property (rd_hi_r > 4'h8 |-> $stable(rd_data_out))
		else $error("read data changed without a read");
endmodule // fcds_top_assertions

// >>> dv/fcds_host_model.sv
`timescale 1ns/1ps
`include "fcds_defs.vh"
// ****
// microcontroller bus host
// ****
module fcds_host_model
(
	// clock
	input wire clk_in,
	// bus pins
	output reg wr_n_out,
	output reg rd_n_out,
	output reg [15:0] addr_out,
	output reg [7:0] data_out,
	output reg [7:0] psel_out,
	// read data
	input wire [7:0] rd_data_in
);
	initial
	begin
		wr_n_out = 1'b1;
		rd_n_out = 1'b1;
		psel_out = 8'h00;
		addr_out = 16'h0000;
		data_out = 8'h00;
	end
	// code runs from the other array, so commands only go to this one
	task bus(input w, input [15:0] a, input [7:0] d, output [7:0] q);
	begin
		@(posedge clk_in);
		addr_out <= a;
		data_out <= d;
		psel_out <= 8'h01;
		@(posedge clk_in);
		if (w)
			wr_n_out <= 1'b0;
		else
			rd_n_out <= 1'b0;
		repeat (8) @(posedge clk_in);
		q = rd_data_in;
		wr_n_out <= 1'b1;
		rd_n_out <= 1'b1;
		repeat (8) @(posedge clk_in);
		psel_out <= 8'h00;
		data_out <= ~d;
	end
	endtask
	task w(input [15:0] a, input [7:0] d);
		reg [7:0] q;
	begin
		bus(1'b1, a, d, q);
	end
	endtask
	task unl(input [7:0] c, input [15:0] a);
	begin
		w(16'hF555, `FCDS_UNLOCK1_DATA);
		w(16'h3AAA, `FCDS_UNLOCK2_DATA);
		w(a, c);
	end
	endtask
endmodule // fcds_host_model

// >>> dv/fcds_top_tb.sv
`timescale 1ns/1ps
`include "fcds_defs.vh"
module fcds_top_tb;
	localparam [7:0] DEV_ID = 8'h3C; // arbitrary value
	reg clk_in = 1'b0;
	reg sys_rst_in = 1'b1;
	reg [7:0] mem_r = 8'h00;
	reg prot_r = 1'b0;
	reg done_r = 1'b0;
	reg fail_r = 1'b0;
	reg [7:0] q, q2, d, tgt;
	reg [31:0] seed = 32'hF04C;
	integer errors = 0, cmp_count = 0, cyc = 0, j, pc [0:4];
	wire wr_n, rd_n, busy, susp, rmode, bulk, tsec;
	wire [15:0] addr, taddr;
	wire [7:0] data, psel, rdat, tdata;
	wire [4:0] pv;
	always #4 clk_in = ~clk_in;
	fcds_host_model host_u (.clk_in(clk_in), .wr_n_out(wr_n), .rd_n_out(rd_n), .addr_out(addr),
		.data_out(data), .psel_out(psel), .rd_data_in(rdat));
	fcds_top #(.GAP_CYC(50), .APPEND_CYC(100), .ALLPROT_CYC(40), .DEVICE_ID(DEV_ID)) dut_u (
		.clk_in(clk_in), .sys_rst_in(sys_rst_in), .wr_n_in(wr_n), .rd_n_in(rd_n),
		.addr_in(addr), .data_in(data), .primary_sector_selects_in(psel),
		.secondary_sector_selects_in(4'h0), .mem_data_in(mem_r), .sect_prot_in(prot_r),
		.algo_done_in(done_r), .algo_fail_in(fail_r), .rd_data_out(rdat),
		.prog_start_out(pv[0]), .erase_start_out(pv[1]), .erase_bulk_out(bulk),
		.sect_add_out(pv[2]), .erase_suspend_out(pv[3]), .erase_resume_out(pv[4]),
		.target_secondary_out(tsec), .target_addr_out(taddr), .target_data_out(tdata),
		.busy_out(busy), .suspended_out(susp), .read_mode_out(rmode));
	function [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task tally_and_finish;
	begin
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	end
	endtask
	always @(posedge clk_in)
	begin
		cyc = cyc + 1;
		if (!sys_rst_in)
			for (j = 0; j < 5; j = j + 1)
				pc[j] = pc[j] + pv[j];
		if (pv[0])
			tgt = tdata;
		if (cyc == 20000)
		begin
			errors = errors + 1;
			tally_and_finish;
		end
	end
	task chk8(input [7:0] got, input [7:0] exp);
	begin
		cmp_count = cmp_count + 1;
		if (got !== exp)
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		if (got !== exp)
			errors = errors + 1;
	end
	endtask
	task chkn(input integer got, input integer exp);
	begin
		cmp_count = cmp_count + 1;
		if (got !== exp)
			$display("mismatch at %0t: count %0d expected %0d", $time, got, exp);
		if (got !== exp)
			errors = errors + 1;
	end
	endtask
	task rd(input [15:0] a);
	begin
		seed = lfsr(seed);
		mem_r <= seed[7:0];
		host_u.bus(1'b0, a, 8'h00, q);
	end
	endtask
	task algo(input f);
	begin
		@(posedge clk_in);
		done_r <= !f;
		fail_r <= f;
		@(posedge clk_in);
		done_r <= 1'b0;
		fail_r <= 1'b0;
		repeat (4) @(posedge clk_in);
	end
	endtask
	task prog(input [15:0] a);
	begin
		seed = lfsr(seed);
		d = seed[7:0];
		host_u.unl(`FCDS_CMD_PROG, 16'h0555);
		host_u.w(a, d);
	end
	endtask
	initial
	begin
		for (j = 0; j < 5; j = j + 1)
			pc[j] = 0;
		repeat (12) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		repeat (6) @(posedge clk_in);
		rd(16'h1234);
		chk8(q, mem_r);
		host_u.unl(`FCDS_CMD_ID, 16'h0555);
		rd(16'hF001);
		chk8(q, DEV_ID);
		prot_r <= 1'b1;
		rd(16'h0002);
		chk8(q, `FCDS_PROT_YES);
		prot_r <= 1'b0;
		rd(16'h0002);
		chk8(q, `FCDS_PROT_NO);
		host_u.w(16'h0000, `FCDS_CMD_RESET);
		rd(16'h0001);
		chk8(q, mem_r);
		$display("test query done");
		prog(16'h2345);
		chkn(pc[0], 1);
		chk8(tgt, d);
		rd(16'h2345);
		q2 = q;
		rd(16'h2345);
		chk8({q2[7], q2[5], q[7], q[6], q[5], 3'h0}, {~d[7], 1'b0, ~d[7], ~q2[6], 1'b0, 3'h0});
		algo(1'b0);
		rd(16'h2345);
		chk8(q, mem_r);
		prog(16'h2346);
		algo(1'b1);
		rd(16'h2346);
		chk8({q[5], 7'h0}, 8'h80);
		host_u.w(16'h0000, `FCDS_CMD_RESET);
		rd(16'h2346);
		chk8(q, mem_r);
		prot_r <= 1'b1;
		prog(16'h2347);
		prot_r <= 1'b0;
		chkn(pc[0], 2);
		$display("test program done");
		host_u.w(16'h0555, `FCDS_UNLOCK1_DATA);
		host_u.w(16'h0AAA, 8'h12);
		rd(16'h0100);
		chk8(q, mem_r);
		host_u.w(16'h0555, `FCDS_UNLOCK1_DATA);
		repeat (80) @(posedge clk_in);
		host_u.w(16'h0AAA, `FCDS_UNLOCK2_DATA);
		host_u.w(16'h0555, `FCDS_CMD_PROG);
		host_u.w(16'h0200, 8'h5B);
		chkn(pc[0], 2);
		host_u.w(16'h0000, `FCDS_CMD_SUSP);
		host_u.w(16'h0000, `FCDS_CMD_RESUME);
		chkn(pc[3] + pc[4], 0);
		$display("test abort done");
		host_u.unl(`FCDS_CMD_ERASE, 16'h0555);
		host_u.unl(`FCDS_CMD_SECT, 16'h4000);
		chkn(pc[1], 1);
		rd(16'h4010);
		chk8({q[7], q[3], 6'h0}, 8'h00);
		host_u.w(16'h5000, `FCDS_CMD_SECT);
		chkn(pc[2], 1);
		repeat (130) @(posedge clk_in);
		rd(16'h4010);
		chk8({q[7], q[3], 6'h0}, 8'h40);
		host_u.w(16'h0000, `FCDS_CMD_SUSP);
		chkn(pc[3], 1);
		rd(16'h7000);
		chk8(q, mem_r);
		host_u.w(16'h0000, `FCDS_CMD_RESUME);
		chkn(pc[4], 1);
		algo(1'b0);
		host_u.unl(`FCDS_CMD_ERASE, 16'h0555);
		host_u.unl(`FCDS_CMD_BULK, 16'h0555);
		chk8({7'h0, bulk}, 8'h01);
		chkn(pc[1], 2);
		algo(1'b0);
		$display("test erase done");
		host_u.unl(`FCDS_CMD_BYPASS, 16'h0555);
		host_u.w(16'h0000, `FCDS_CMD_PROG);
		host_u.w(16'h3456, 8'hC3);
		chkn(pc[0], 3);
		chk8(tgt, 8'hC3);
		algo(1'b0);
		host_u.w(16'h0000, `FCDS_CMD_ID);
		host_u.w(16'h0000, `FCDS_CMD_BYP_EXIT);
		rd(16'h3456);
		chk8(q, mem_r);
		$display("test bypass done");
		tally_and_finish;
	end
endmodule // fcds_top_tb
bind fcds_top fcds_top_assertions chk_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
	.rd_n_in(rd_n_in), .sect_prot_in(sect_prot_in), .rd_data_out(rd_data_out),
	.prog_start_out(prog_start_out), .erase_start_out(erase_start_out),
	.sect_add_out(sect_add_out), .erase_suspend_out(erase_suspend_out),
	.erase_resume_out(erase_resume_out), .busy_out(busy_out),
	.suspended_out(suspended_out), .read_mode_out(read_mode_out));
